// ===== tdes_pkg.sv
// Purpose: constants for the transmit descriptor error status block
// Assumes: AHB-Lite register window of four words
// Notes: bit positions follow the descriptor status word layout
package tdes_pkg;
    // register byte offsets
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    localparam logic [3:0] ELOG_OFS = 4'h8;
    localparam logic [3:0] DIST_OFS = 4'hc;
    // control register fields
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_SINGLE_BIT = 1;
    // status word bit positions
    localparam int BIT_CHAIN = 15;
    localparam int BIT_UNDERRUN = 14;
    localparam int BIT_RESERVED = 13;
    localparam int BIT_LATE = 12;
    localparam int BIT_CARRIER = 11;
    localparam int BIT_RETRY = 10;
    localparam int DIST_W = 10;
    // attempt limits
    localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
    localparam logic [4:0] SINGLE_ATTEMPTS = 5'h01;
    // reset values and distance count limit
    localparam logic [5:0] ELOG_RST = 6'h00;
    localparam logic [DIST_W-1:0] DIST_RST = 10'h000;
    localparam logic [DIST_W-1:0] DIST_MAX = 10'h3ff;
    typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT} tdes_state_t;
endpackage

// ===== tdes_top.sv
// Functional notes
// - set chain error when buffer lacks end marker and next is not owned
// - chain error on unowned next buffer or underrun before lookahead poll
// - chain error turns transmitter off; host clears the flag
// - chain error always also sets underrun flag
// - fifo empty before frame end truncates frame and sets underrun
// - underrun turns transmitter off
// - reserved status bit always written as zero
// - late collision sets its flag and frame is not retried
// - carrier sense falling during own transmission sets carrier loss
// - after carrier loss keep sending whole frame, no retry
// - retry flag after sixteen collision-failed attempts
// - single attempt mode sets retry flag after one failure
// - counter from attempt start to collision reported in low ten bits
// - error summary is OR of late, carrier, underrun, retry flags
// - on error write status, release descriptor, raise interrupt
// - status word written only when frame had an error
//
// Purpose: transmit error status and descriptor write-back
// Assumes: tx path inputs synchronous to ref_clk_in
// Notes: registers over AHB-Lite, zero wait states
//
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
module tdes_top (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic tx_start_in,
    input wire logic collision_in,
    input wire logic slot_elapsed_in,
    input wire logic receive_carrier_sense_in,
    input wire logic fifo_empty_in,
    input wire logic end_of_frame_marker_in,
    input wire logic next_owned_in,
    input wire logic lookahead_done_in,
    input wire logic buffer_done_in,
    input wire logic frame_done_in,
    output logic transmitter_on_out,
    output logic truncate_out,
    output logic retry_out,
    output logic desc_write_out,
    output logic desc_release_out,
    output logic [15:0] tx_descriptor_status_word_out,
    output logic desc_error_summary_out,
    output logic tx_interrupt_flag_out
);
    import tdes_pkg::*;

    tdes_state_t state_q, state_d;
    logic wr_pend_q;
    logic [3:0] wr_addr_q;
    logic single_attempt_mode_q;
    logic [5:0] elog_q, elog_d;
    logic [DIST_W-1:0] dist_last_q;
    logic [DIST_W-1:0] dist_q;
    logic dist_hold_q;
    logic [4:0] attempts_q;
    logic carrier_prev_q;
    logic buffer_chain_error_q;
    logic fifo_underrun_error_q;
    logic late_collision_flag_q;
    logic carrier_loss_flag_q;
    logic retry_exhausted_flag_q;
    logic transmitter_on_d;

    // bus decode
    wire ahb_go = hsel_in & htrans_in[1] & hready_in;
    wire addr_ok = haddr_in[31:4] == 28'h0000000;
    wire [3:0] a_ofs = {haddr_in[3:2], 2'h0};
    wire wr_now = wr_pend_q;
    wire wr_ctrl = wr_now & (wr_addr_q == CTRL_OFS);
    wire wr_elog = wr_now & (wr_addr_q == ELOG_OFS);
    wire [31:0] ctrl_word = {30'h0, single_attempt_mode_q, transmitter_on_out};
    wire [31:0] stat_word = {25'h0, attempts_q, state_q};
    wire [31:0] elog_word = {16'h0, elog_q, 10'h000};
    wire [31:0] dist_word = {22'h0, dist_last_q};
    wire [31:0] rd_word = !addr_ok ? 32'h0 :
        a_ofs == CTRL_OFS ? ctrl_word :
        a_ofs == STAT_OFS ? stat_word :
        a_ofs == ELOG_OFS ? elog_word : dist_word;

    // frame events
    wire in_send = state_q == ST_SEND;
    wire start_ok = (state_q == ST_IDLE) & tx_start_in & transmitter_on_out;
    wire restart = (state_q == ST_WAIT) & tx_start_in;
    wire coll = in_send & collision_in;
    wire late_coll = coll & slot_elapsed_in;
    wire early_coll = coll & ~slot_elapsed_in;
    wire [4:0] limit = single_attempt_mode_q ? SINGLE_ATTEMPTS : MAX_ATTEMPTS;
    wire [4:0] attempts_next = attempts_q + 5'h01;
    wire exhaust = early_coll & (attempts_next >= limit);
    wire retry = early_coll & ~exhaust;
    wire car_lost = in_send & carrier_prev_q & ~receive_carrier_sense_in;
    // no end marker, next not owned
    // or fifo ran dry before lookahead
    wire chain_err = in_send & ~end_of_frame_marker_in &
        ((buffer_done_in & ~next_owned_in) | (fifo_empty_in & ~lookahead_done_in));
    wire underrun = in_send & fifo_empty_in;
    wire abort = late_coll | exhaust | underrun | chain_err;
    wire finish = in_send & (frame_done_in | abort);

    // next flag values include same-cycle events
    wire chain_d = buffer_chain_error_q | chain_err;
    wire under_d = fifo_underrun_error_q | underrun | chain_err;
    wire late_d = late_collision_flag_q | late_coll;
    wire car_d = carrier_loss_flag_q | car_lost;
    wire retry_exhausted_flag_d = retry_exhausted_flag_q | exhaust;
    wire summary_d = late_d | car_d | under_d | retry_exhausted_flag_d;
    wire err_d = summary_d | chain_d;
    wire [15:0] word_d = {chain_d, under_d, 1'b0, late_d, car_d, retry_exhausted_flag_d, dist_q};

    // underrun forces transmitter off
    // hardware off wins over a software turn-on in the same cycle
    assign transmitter_on_d = (underrun | chain_err) ? 1'b0 :
        wr_ctrl ? hwdata_in[CTRL_ON_BIT] : transmitter_on_out;

    // sticky log, set wins over write-one-to-clear
    wire [5:0] elog_set = (finish & err_d) ? word_d[15:10] : 6'h00;
    wire [5:0] elog_clr = wr_elog ? hwdata_in[15:10] : 6'h00;
    assign elog_d = (elog_q & ~elog_clr) | elog_set;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (start_ok) begin
                    state_d = ST_SEND;
                end
            end
            ST_SEND: begin
                if (finish) begin
                    state_d = ST_IDLE;
                end else if (retry) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (restart) begin
                    state_d = ST_SEND;
                end
            end
        endcase
    end

    // bus slave
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= CTRL_OFS;
            hrdata_out <= 32'h0;
            hreadyout_out <= 1'b0;
            hresp_out <= 1'b0;
        end else begin
            wr_pend_q <= ahb_go & hwrite_in & addr_ok;
            wr_addr_q <= a_ofs;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
            if (ahb_go & ~hwrite_in) begin
                hrdata_out <= rd_word;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            single_attempt_mode_q <= 1'b0;
            transmitter_on_out <= 1'b0;
            elog_q <= ELOG_RST;
            state_q <= ST_IDLE;
        end else begin
            if (wr_ctrl) begin
                single_attempt_mode_q <= hwdata_in[CTRL_SINGLE_BIT];
            end
            transmitter_on_out <= transmitter_on_d;
            elog_q <= elog_d;
            state_q <= state_d;
        end
    end

    // per-frame flags, cleared at first attempt only
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in | start_ok) begin
            buffer_chain_error_q <= 1'b0;
            fifo_underrun_error_q <= 1'b0;
            late_collision_flag_q <= 1'b0;
            carrier_loss_flag_q <= 1'b0;
            retry_exhausted_flag_q <= 1'b0;
            attempts_q <= 5'h00;
        end else if (in_send) begin
            buffer_chain_error_q <= chain_d;
            fifo_underrun_error_q <= under_d;
            late_collision_flag_q <= late_d;
            carrier_loss_flag_q <= car_d;
            retry_exhausted_flag_q <= retry_exhausted_flag_d;
            if (early_coll) begin
                attempts_q <= attempts_next;
            end
        end
    end

    // count from attempt start until collision
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in | start_ok | restart) begin
            dist_q <= DIST_RST;
            dist_hold_q <= 1'b0;
            carrier_prev_q <= 1'b0;
        end else if (in_send) begin
            carrier_prev_q <= receive_carrier_sense_in;
            if (coll) begin
                dist_hold_q <= 1'b1;
            end else if (~dist_hold_q && dist_q != DIST_MAX) begin
                dist_q <= dist_q + 10'h001;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            dist_last_q <= DIST_RST;
            truncate_out <= 1'b0;
            retry_out <= 1'b0;
            desc_write_out <= 1'b0;
            desc_release_out <= 1'b0;
            tx_descriptor_status_word_out <= 16'h0000;
            desc_error_summary_out <= 1'b0;
            tx_interrupt_flag_out <= 1'b0;
        end else begin
            truncate_out <= underrun | chain_err;
            retry_out <= retry;
            // word and release in one cycle
            desc_write_out <= finish & err_d;
            desc_release_out <= finish;
            tx_interrupt_flag_out <= finish;
            if (finish) begin
                tx_descriptor_status_word_out <= word_d;
                desc_error_summary_out <= summary_d;
                dist_last_q <= dist_q;
            end
        end
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence s_err_writeback;
        desc_write_out && desc_release_out && tx_interrupt_flag_out;
    endsequence

    a_chain_flagged: assert property (
        chain_err |=> s_err_writeback ##0 tx_descriptor_status_word_out[BIT_CHAIN])
        else $error("chain error not written back");
    a_chain_cause: assert property (
        in_send && end_of_frame_marker_in && !fifo_empty_in |=> !truncate_out)
        else $error("chain error without cause");
    a_chain_txoff: assert property (
        chain_err |=> !transmitter_on_out && truncate_out)
        else $error("transmitter left on after chain error");
    a_chain_underrun: assert property (
        desc_write_out && tx_descriptor_status_word_out[BIT_CHAIN]
        |-> tx_descriptor_status_word_out[BIT_UNDERRUN])
        else $error("chain error without underrun");
    a_underrun_trunc: assert property (
        underrun |=> truncate_out ##0 tx_descriptor_status_word_out[BIT_UNDERRUN])
        else $error("underrun not truncated");
    a_underrun_txoff: assert property (
        underrun |=> !transmitter_on_out ##1 state_q == ST_IDLE)
        else $error("transmitter on after underrun");
    a_reserved_zero: assert property (
        desc_write_out |-> !tx_descriptor_status_word_out[BIT_RESERVED])
        else $error("reserved bit written as one");
    a_late_noretry: assert property (
        late_coll |=> !retry_out && tx_descriptor_status_word_out[BIT_LATE])
        else $error("late collision retried");
    a_carrier_flag: assert property (
        car_lost && finish |=> tx_descriptor_status_word_out[BIT_CARRIER])
        else $error("carrier loss not flagged");
    a_carrier_cont: assert property (
        car_lost && !finish && !retry |=> state_q == ST_SEND && !retry_out)
        else $error("send stopped on carrier loss");
    a_retry_limit: assert property (
        early_coll && !finish && !single_attempt_mode_q && attempts_q < 5'h0f
        |=> retry_out ##0 state_q == ST_WAIT)
        else $error("retry given up too early");
    a_single_try: assert property (
        early_coll && single_attempt_mode_q
        |=> !retry_out ##0 tx_descriptor_status_word_out[BIT_RETRY])
        else $error("single attempt mode retried");
    a_dist_frozen: assert property (
        coll || (dist_hold_q && !start_ok && !restart) |=> $stable(dist_q))
        else $error("distance count moved after collision");
    a_summary_or: assert property (
        desc_release_out |-> desc_error_summary_out ==
        (|tx_descriptor_status_word_out[BIT_UNDERRUN:BIT_RETRY]))
        else $error("error summary mismatch");
    a_error_release: assert property (
        finish && err_d |=> s_err_writeback)
        else $error("error frame not released");
    a_clean_nowrite: assert property (
        finish && !err_d |=> desc_release_out && !desc_write_out)
        else $error("status written without error");
    a_single_write: assert property (
        desc_write_out |-> desc_release_out ##1 !desc_write_out)
        else $error("status write split from release");
endmodule
`default_nettype wire

// ===== tdes_host_mem.sv
// Purpose: host memory side of the transmit descriptor ring
// Assumes: one status word slot stands for the current descriptor
// Notes: ownership of the next descriptor is granted by the bench
`timescale 1ns/1ns
`default_nettype none
module tdes_host_mem (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic give_next_in,
    input wire logic desc_write_in,
    input wire logic desc_release_in,
    input wire logic [15:0] status_word_in,
    output logic next_owned_out,
    output logic [15:0] mem_word_out,
    output logic chain_valid_out,
    output logic count_valid_out
);
    logic own_q;
    logic [15:0] word_q;
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            own_q <= 1'b0;
            word_q <= 16'h0000;
        end else begin
            own_q <= give_next_in;
            if (desc_write_in && desc_release_in) begin
                word_q <= status_word_in;
            end else if (give_next_in && !own_q) begin
                word_q <= 16'h0000;
            end
        end
    end
    assign next_owned_out = own_q;
    assign mem_word_out = word_q;
    assign chain_valid_out = word_q[15] & ~word_q[12] & ~word_q[10];
    // no loopback in this model, carrier flag always trusted
    assign count_valid_out = word_q[10];
endmodule
`default_nettype wire

// ===== tdes_top_tb.sv
// Purpose: self-checking bench for the transmit error status block
// Assumes: zero wait AHB-Lite slave, tx inputs driven on clock edges
// Notes: distance count checked by difference, not absolute value
`timescale 1ns/1ns
`default_nettype none
module tdes_top_tb;
    import tdes_pkg::*;
    typedef struct packed {
        logic [1:0] ctrl;
        logic eom, look, own, slot, carr;
        logic [2:0] ev;
        logic [3:0] dly;
        logic [15:0] hi;
        logic wr, trunc, transmitter_on;
    } tdes_row_t;
    // ev: 0 fifo empty, 1/4 collision, 2 buffer done, 3 carrier drop, 5 frame done
    tdes_row_t rows [8] = '{
        '{2'h1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 4'h3, 16'h4000, 1'b1, 1'b1, 1'b0},
        '{2'h1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 3'h1, 4'h4, 16'h1000, 1'b1, 1'b0, 1'b1},
        '{2'h1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 3'h2, 4'h3, 16'hc000, 1'b1, 1'b1, 1'b0},
        '{2'h1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 4'h3, 16'hc000, 1'b1, 1'b1, 1'b0},
        '{2'h1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 3'h0, 4'h3, 16'h4000, 1'b1, 1'b1, 1'b0},
        '{2'h3, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 3'h4, 4'h5, 16'h0400, 1'b1, 1'b0, 1'b1},
        '{2'h1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 3'h3, 4'h4, 16'h0800, 1'b1, 1'b0, 1'b1},
        '{2'h1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 3'h5, 4'h4, 16'h0000, 1'b0, 1'b0, 1'b1}};
    logic ref_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata_out, rd;
    logic hreadyout_out, hresp_out, transmitter_on_out, truncate_out, retry_out;
    logic desc_write_out, desc_release_out, desc_error_summary_out, tx_interrupt_flag_out;
    logic [15:0] tx_descriptor_status_word_out, mem_word, c_word;
    logic tx_start = 1'b0, collision = 1'b0, slot = 1'b0, carr = 1'b0, fifo = 1'b0;
    logic eom = 1'b1, look = 1'b0, give = 1'b0, next_owned, bdone = 1'b0, fdone = 1'b0;
    logic c_wr, c_tr, c_on, c_int, c_sum, chain_ok, count_ok;
    logic [9:0] late_cnt;
    int rels = 0, retries = 0, failures = 0, checks = 0, cyc = 0, n0;
    tdes_top DUT (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
        .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .tx_start_in(tx_start),
        .collision_in(collision), .slot_elapsed_in(slot), .receive_carrier_sense_in(carr),
        .fifo_empty_in(fifo), .end_of_frame_marker_in(eom), .next_owned_in(next_owned),
        .lookahead_done_in(look), .buffer_done_in(bdone), .frame_done_in(fdone),
        .transmitter_on_out(transmitter_on_out), .truncate_out(truncate_out),
        .retry_out(retry_out), .desc_write_out(desc_write_out),
        .desc_release_out(desc_release_out),
        .tx_descriptor_status_word_out(tx_descriptor_status_word_out),
        .desc_error_summary_out(desc_error_summary_out),
        .tx_interrupt_flag_out(tx_interrupt_flag_out));
    tdes_host_mem host (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .give_next_in(give),
        .desc_write_in(desc_write_out), .desc_release_in(desc_release_out),
        .status_word_in(tx_descriptor_status_word_out), .next_owned_out(next_owned),
        .mem_word_out(mem_word), .chain_valid_out(chain_ok), .count_valid_out(count_ok));
    initial begin
        forever #10 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (desc_release_out === 1'b1) begin
            rels <= rels + 1;
            c_word <= tx_descriptor_status_word_out;
            c_wr <= desc_write_out;
            c_tr <= truncate_out;
            c_on <= transmitter_on_out;
            c_int <= tx_interrupt_flag_out;
            c_sum <= desc_error_summary_out;
        end
        if (retry_out === 1'b1)
            retries <= retries + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            complete_run();
        end
    end
    task automatic complete_run();
        if (failures == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmp_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks = checks + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp_flag(input string nm, input logic e, input logic g);
        cmp_val(nm, {31'h0, e}, {31'h0, g});
    endtask
    task automatic ahb(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        @(posedge ref_clk_in);
        hsel <= 1'b1;
        haddr <= {28'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge ref_clk_in);
        while (hreadyout_out !== 1'b1) @(posedge ref_clk_in);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge ref_clk_in);
        while (hreadyout_out !== 1'b1) @(posedge ref_clk_in);
        rd = hrdata_out;
        cmp_flag("hresp", 1'b0, hresp_out);
    endtask
    task automatic pulse_start();
        @(posedge ref_clk_in);
        tx_start <= 1'b1;
        @(posedge ref_clk_in);
        tx_start <= 1'b0;
    endtask
    task automatic wait_rel();
        while (rels == n0) begin
            @(posedge ref_clk_in);
            #1;
        end
    endtask
    task automatic run_row(input tdes_row_t r);
        n0 = rels;
        ahb(1'b1, CTRL_OFS, {30'h0, r.ctrl});
        @(posedge ref_clk_in);
        eom <= r.eom;
        look <= r.look;
        give <= r.own;
        slot <= r.slot;
        carr <= r.carr;
        pulse_start();
        repeat (r.dly) @(posedge ref_clk_in);
        case (r.ev)
            3'h0: fifo <= 1'b1;
            3'h2: bdone <= 1'b1;
            3'h3: carr <= 1'b0;
            3'h5: fdone <= 1'b1;
            default: collision <= 1'b1;
        endcase
        @(posedge ref_clk_in);
        {fifo, bdone, collision, fdone} <= 4'h0;
        if (r.ev == 3'h3) begin
            repeat (2) @(posedge ref_clk_in);
            fdone <= 1'b1;
            @(posedge ref_clk_in);
            fdone <= 1'b0;
        end
        wait_rel();
        cmp_val("word_flags", {16'h0, r.hi}, {16'h0, c_word & 16'hfc00});
        cmp_flag("desc_write", r.wr, c_wr);
        cmp_flag("truncate", r.trunc, c_tr);
        cmp_flag("tx_on", r.transmitter_on, c_on);
        cmp_flag("tx_int", 1'b1, c_int);
        cmp_flag("summary", |{r.hi[14], r.hi[12:10]}, c_sum);
        if (r.wr) begin
            cmp_val("mem_word", {16'h0, r.hi}, {16'h0, mem_word & 16'hfc00});
            cmp_flag("chain_valid", r.hi[15] & ~r.hi[12] & ~r.hi[10], chain_ok);
            cmp_flag("count_valid", r.hi[10], count_ok);
        end
        if (r.ev == 3'h1)
            late_cnt = c_word[9:0];
    endtask
    initial begin
        repeat (16) @(posedge ref_clk_in);
        cmp_flag("ready_in_reset", 1'b0, hreadyout_out);
        sys_rst_in <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            ahb(1'b0, 4'(i * 4), 32'h0);
            cmp_val("reset_reg", 32'h0, rd);
        end
        foreach (rows[i])
            run_row(rows[i]);
        ahb(1'b0, ELOG_OFS, 32'h0);
        cmp_val("elog", 32'h0000dc00, rd);
        ahb(1'b1, ELOG_OFS, 32'h0000ffff);
        ahb(1'b0, ELOG_OFS, 32'h0);
        cmp_val("elog_clear", 32'h0, rd);
        // transmitter off: start and underrun ignored
        n0 = rels;
        ahb(1'b1, CTRL_OFS, 32'h0);
        pulse_start();
        fifo <= 1'b1;
        @(posedge ref_clk_in);
        fifo <= 1'b0;
        repeat (6) @(posedge ref_clk_in);
        cmp_val("rel_when_off", n0, rels);
        // sixteen failed attempts, last one longer
        n0 = retries;
        ahb(1'b1, CTRL_OFS, 32'h1);
        slot <= 1'b0;
        for (int a = 0; a < 16; a++) begin
            pulse_start();
            repeat (a == 15 ? 12 : 4) @(posedge ref_clk_in);
            collision <= 1'b1;
            @(posedge ref_clk_in);
            collision <= 1'b0;
            repeat (3) @(posedge ref_clk_in);
        end
        cmp_val("retries", n0 + 15, retries);
        n0 = rels - 1;
        wait_rel();
        cmp_val("retry_word", 32'h0400, {16'h0, c_word & 16'hfc00});
        cmp_flag("count_valid_end", 1'b1, count_ok);
        cmp_val("count_delta", 32'h8, {22'h0, c_word[9:0] - late_cnt});
        ahb(1'b0, DIST_OFS, 32'h0);
        cmp_val("dist_reg", {22'h0, late_cnt + 10'h8}, rd);
        complete_run();
    end
endmodule
`default_nettype wire
